//--- hw/alx_exec.sv
// Execution datapath: add, and, shifts, pointer adjust, branch, bit clear
//
// Contract
// - Add writes accumulator plus operand, fixed cycles
// - Add sets overflow flag on signed overflow
// - Add sets nibble carry from bit three
// - Add sets borrow_out on carry out
// - Msb and zero flags follow the result
// - Stack adjust adds sign-extended immediate, no flags
// - Index adjust adds sign-extended immediate, no flags
// - And clears overflow, keeps nibble and borrow
// - Left shift inserts zero at bit zero
// - Left shift borrow_out gets old bit seven
// - Left shift opcode and cycle table
// - Shift overflow equals msb xor borrow
// - Right shift keeps bit seven
// - Right shift borrow_out gets old bit zero
// - Right shift opcode and cycle table
// - Branch when borrow clear to pc plus two
// - Flag byte bit positions are fixed
// - Branch offset is signed last byte
// - Bit clear read-modify-writes zero-page byte, no flags
`timescale 1ns/100ps
module alx_exec import alx_pkg::*; (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // Instruction start
  input  wire logic        i_start,
  input  wire logic [15:0] i_opcode,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_bad_opcode,
  // Memory bus, asynchronous read
  output logic [15:0]      o_mem_addr,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic [7:0]       o_mem_wdata,
  input  wire logic [7:0]  i_mem_rdata,
  // Register load
  input  wire logic        i_load,
  input  wire logic [7:0]  i_load_acc,
  input  wire logic [15:0] i_load_index,
  input  wire logic [15:0] i_load_stack,
  input  wire logic [15:0] i_load_pc,
  input  wire logic [7:0]  i_load_flags,
  // Programmer-visible state
  output logic [7:0]       o_acc,
  output logic [15:0]      o_index,
  output logic [15:0]      o_stack_top,
  output logic [15:0]      o_pc,
  output logic [7:0]       o_flags
);

  typedef enum logic [1:0] {
    ALX_S_IDLE, ALX_S_BYTE2, ALX_S_MEM, ALX_S_FIN
  } alx_state_t;

  alx_state_t  state_reg, state_next;
  logic [15:0] op_reg;
  logic [2:0]  cyc_reg;
  logic [7:0]  hi_reg;
  logic [15:0] addr_reg;
  logic [7:0]  opnd_reg, tgt_reg, res_reg, fres_reg;
  logic [7:0]  acc_reg, flags_reg;
  logic [15:0] idx_reg, stk_reg, pc_reg;
  logic        done_reg, bad_reg;

  // Decoder sees the new opcode while idle, the held one after
  logic        idle, d_valid;
  logic [15:0] cur_op;
  alx_kind_t   d_kind;
  alx_mode_t   d_mode;
  alx_tgt_t    d_tgt;
  logic [2:0]  d_bit, d_cyc;
  assign idle   = (state_reg == ALX_S_IDLE);
  assign cur_op = idle ? i_opcode : op_reg;

  alx_decode u_dec (
    .i_opcode (cur_op),
    .o_valid  (d_valid),
    .o_kind   (d_kind),
    .o_mode   (d_mode),
    .o_target (d_tgt),
    .o_bitsel (d_bit),
    .o_cycles (d_cyc)
  );

  // Mode classes and operand pointer
  logic        pre, word_mode, self_mode, inh_mode;
  logic [15:0] opnd_ptr, ptr_base;
  assign pre       = (cur_op[15:8] == ALX_PREFIX);
  assign word_mode = (alx_opnd_bytes(d_mode) == 2'd2);
  assign inh_mode  = (d_mode == ALX_M_IMPLIED);
  assign self_mode = (d_mode == ALX_M_INLINE) ||
                     (d_mode == ALX_M_RELATIVE) ||
                     (d_mode == ALX_M_PTR_NONE);
  assign opnd_ptr  = pc_reg + (pre ? 16'h0002 : 16'h0001);
  assign ptr_base  = (d_mode == ALX_M_PTR_BYTE || d_mode == ALX_M_PTR_WORD)
                     ? idx_reg
                     : (d_mode == ALX_M_STK_BYTE || d_mode == ALX_M_STK_WORD)
                     ? stk_reg : 16'h0000;

  // Start, operand latch and commit strobes
  logic start_ok, rd_idle, lat_go, inh_go, fin_go, commit;
  assign start_ok = idle && i_start;
  assign rd_idle  = start_ok && d_valid && !inh_mode;
  assign lat_go   = (rd_idle && self_mode) || (state_reg == ALX_S_MEM);
  assign inh_go   = start_ok && d_valid && inh_mode;
  assign fin_go   = (state_reg == ALX_S_FIN) &&
                    (cyc_reg == d_cyc - 3'd1);
  assign commit   = inh_go || fin_go;

  // Memory bus drive
  assign o_mem_rd   = rd_idle || (!idle && state_reg != ALX_S_FIN);
  assign o_mem_wr   = fin_go && (d_tgt == ALX_T_MEM);
  assign o_mem_wdata = res_reg;
  assign o_mem_addr = (state_reg == ALX_S_BYTE2) ? opnd_ptr + 16'h0001
                    : !idle ? addr_reg
                    : (d_mode == ALX_M_PTR_NONE) ? idx_reg : opnd_ptr;

  // Shared result unit
  logic [7:0] alu_t, alu_res, alu_flags;
  assign alu_t = (d_tgt == ALX_T_ACC) ? acc_reg
               : (d_tgt == ALX_T_XLO) ? idx_reg[7:0] : i_mem_rdata;

  alx_alu u_alu (
    .i_kind    (d_kind),
    .i_target  (alu_t),
    .i_operand (i_mem_rdata),
    .i_bitsel  (d_bit),
    .i_flags   (flags_reg),
    .o_result  (alu_res),
    .o_flags   (alu_flags)
  );

  // Committed values, new program counter
  logic [7:0]  c_res, c_flags;
  logic [15:0] pc_seq, pc_taken, pc_new;
  logic        br_take;
  assign c_res    = inh_go ? alu_res : res_reg;
  assign c_flags  = inh_go ? alu_flags : fres_reg;
  assign pc_seq   = pc_reg + 16'h0001 + {15'h0000, pre} +
                    {14'h0000, alx_opnd_bytes(d_mode)};
  assign pc_taken = pc_reg + BR_BASE + alx_sext(opnd_reg);
  assign br_take  = (d_kind == ALX_K_BRANCH) && !flags_reg[FLG_BORROW];
  assign pc_new   = br_take ? pc_taken : pc_seq;

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ALX_S_IDLE: if (rd_idle) state_next = self_mode ? ALX_S_FIN
                    : word_mode ? ALX_S_BYTE2 : ALX_S_MEM;
      ALX_S_BYTE2: state_next = ALX_S_MEM;
      ALX_S_MEM:   state_next = ALX_S_FIN;
      default:     if (fin_go) state_next = ALX_S_IDLE;
    endcase
  end

  // Sequencer state and operand capture
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= ALX_S_IDLE;
      op_reg    <= 16'h0000;
      cyc_reg   <= 3'h0;
      hi_reg    <= 8'h00;
      addr_reg  <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (start_ok) op_reg <= i_opcode;
      cyc_reg <= start_ok ? 3'h1 : (idle ? 3'h0 : cyc_reg + 3'h1);
      if (rd_idle) hi_reg <= i_mem_rdata;
      if (rd_idle) begin
        addr_reg <= (d_mode == ALX_M_PTR_NONE) ? idx_reg
                    : ptr_base + {8'h00, i_mem_rdata};
      end else if (state_reg == ALX_S_BYTE2) begin
        addr_reg <= ptr_base + {hi_reg, i_mem_rdata};
      end
    end
  end

  // Operand, target and result latches
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      opnd_reg <= 8'h00;
      tgt_reg  <= 8'h00;
      res_reg  <= 8'h00;
      fres_reg <= RST_FLAGS;
    end else if (lat_go) begin
      opnd_reg <= i_mem_rdata;
      tgt_reg  <= alu_t;
      res_reg  <= alu_res;
      fres_reg <= alu_flags;
    end
  end

  // Programmer-visible registers
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      acc_reg   <= RST_ACC;
      idx_reg   <= RST_INDEX;
      stk_reg   <= RST_STACK;
      pc_reg    <= RST_PC;
      flags_reg <= RST_FLAGS;
    end else if (commit) begin
      pc_reg <= pc_new;
      if (d_kind == ALX_K_ADD || d_kind == ALX_K_AND ||
          d_kind == ALX_K_ASL || d_kind == ALX_K_ASR) begin
        flags_reg <= c_flags;
      end
      if (d_tgt == ALX_T_ACC && d_kind != ALX_K_STACK_ADJ &&
          d_kind != ALX_K_INDEX_ADJ && d_kind != ALX_K_BRANCH) begin
        acc_reg <= c_res;
      end
      if (d_tgt == ALX_T_XLO) idx_reg <= {idx_reg[15:8], c_res};
      if (d_kind == ALX_K_INDEX_ADJ) begin
        idx_reg <= idx_reg + alx_sext(opnd_reg);
      end
      if (d_kind == ALX_K_STACK_ADJ) begin
        stk_reg <= stk_reg + alx_sext(opnd_reg);
      end
    end else if (idle && !i_start && i_load) begin
      acc_reg   <= i_load_acc;
      idx_reg   <= i_load_index;
      stk_reg   <= i_load_stack;
      pc_reg    <= i_load_pc;
      flags_reg <= i_load_flags | FLG_FIXED_ONES;
    end
  end

  // Completion pulses
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      done_reg <= 1'b0;
      bad_reg  <= 1'b0;
    end else begin
      done_reg <= commit || (start_ok && !d_valid);
      bad_reg  <= start_ok && !d_valid;
    end
  end

  assign o_busy       = !idle;
  assign o_done       = done_reg;
  assign o_bad_opcode = bad_reg;
  assign o_acc        = acc_reg;
  assign o_index      = idx_reg;
  assign o_stack_top  = stk_reg;
  assign o_pc         = pc_reg;
  assign o_flags      = flags_reg;

  // Checks on committed results
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  logic k_add, k_and, k_sh;
  assign k_add = fin_go && d_kind == ALX_K_ADD;
  assign k_and = fin_go && d_kind == ALX_K_AND;
  assign k_sh  = commit && (d_kind == ALX_K_ASL || d_kind == ALX_K_ASR);

  property p_add_sum;
    k_add |=> o_acc == 8'($past(acc_reg) + $past(opnd_reg));
  endproperty
  a_add_sum: assert property (p_add_sum)
    else $error("add result wrong");
  property p_add_ovf;
    k_add |=> o_flags[FLG_SERR] ==
      (($past(acc_reg[7]) == $past(opnd_reg[7])) &&
       (o_acc[7] != $past(acc_reg[7])));
  endproperty
  a_add_ovf: assert property (p_add_ovf)
    else $error("add overflow flag wrong");
  property p_add_half;
    k_add |=> o_flags[FLG_NIB] ==
      (($past(acc_reg[3]) && $past(opnd_reg[3])) ||
       ($past(opnd_reg[3]) && !o_acc[3]) || (!o_acc[3] && $past(acc_reg[3])));
  endproperty
  a_add_half: assert property (p_add_half)
    else $error("add nibble carry wrong");
  property p_add_carry;
    k_add |=> o_flags[FLG_BORROW] ==
      (($past(acc_reg[7]) && $past(opnd_reg[7])) ||
       ($past(opnd_reg[7]) && !o_acc[7]) || (!o_acc[7] && $past(acc_reg[7])));
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add carry wrong");
  property p_nz;
    (k_add || k_and || k_sh) |=> o_flags[FLG_MSB] == $past(c_res[7]) &&
      o_flags[FLG_ZERO] == ($past(c_res) == 8'h00);
  endproperty
  a_nz: assert property (p_nz)
    else $error("msb or zero flag wrong");
  property p_stack_adj;
    (fin_go && d_kind == ALX_K_STACK_ADJ) |=> $stable(o_flags) &&
      o_stack_top == $past(stk_reg) + alx_sext($past(opnd_reg));
  endproperty
  a_stack_adj: assert property (p_stack_adj)
    else $error("stack adjust wrong");
  property p_index_adj;
    (fin_go && d_kind == ALX_K_INDEX_ADJ) |=> $stable(o_flags) &&
      o_index == $past(idx_reg) + alx_sext($past(opnd_reg));
  endproperty
  a_index_adj: assert property (p_index_adj)
    else $error("index adjust wrong");
  property p_and;
    k_and |=> o_acc == ($past(acc_reg) & $past(opnd_reg)) &&
      !o_flags[FLG_SERR] && $stable(o_flags[FLG_NIB]) &&
      $stable(o_flags[FLG_BORROW]);
  endproperty
  a_and: assert property (p_and)
    else $error("and result or flags wrong");
  property p_shift_v;
    k_sh |=> o_flags[FLG_SERR] == (o_flags[FLG_MSB] ^ o_flags[FLG_BORROW]);
  endproperty
  a_shift_v: assert property (p_shift_v)
    else $error("shift overflow flag wrong");
  property p_shl_mem;
    (fin_go && d_kind == ALX_K_ASL) |=>
      o_flags[FLG_BORROW] == $past(tgt_reg[7]) &&
      $past(res_reg) == {$past(tgt_reg[6:0]), 1'b0};
  endproperty
  a_shl_mem: assert property (p_shl_mem)
    else $error("left shift wrong");
  property p_branch;
    (fin_go && d_kind == ALX_K_BRANCH) |=> $stable(o_flags) &&
      o_pc == ($past(flags_reg[FLG_BORROW]) ? $past(pc_reg) + BR_BASE
               : $past(pc_reg) + BR_BASE + alx_sext($past(opnd_reg)));
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch target wrong");

  c_add_done:  cover property (k_add ##1 o_done);
  c_shift_mem: cover property (k_sh && o_mem_wr);
  c_br_taken:  cover property (fin_go && br_take);
  c_bad_op:    cover property (o_bad_opcode);

endmodule : alx_exec

//--- hw/alx_pkg.sv
// Constants, types and helpers shared by the execution datapath
package alx_pkg;

  // Opcode prefix byte and the plain-page marker
  localparam logic [7:0] ALX_PREFIX    = 8'h9e;
  localparam logic [7:0] ALX_NO_PREFIX = 8'h00;

  // Whole opcodes
  localparam logic [7:0] OPC_STACK_ADJ = 8'ha7;
  localparam logic [7:0] OPC_INDEX_ADJ = 8'haf;
  localparam logic [7:0] OPC_BR_CC     = 8'h24;

  // Low nibble selects the operation
  localparam logic [3:0] NIB_ADD = 4'hb;
  localparam logic [3:0] NIB_AND = 4'h4;
  localparam logic [3:0] NIB_SHL = 4'h8;
  localparam logic [3:0] NIB_SHR = 4'h7;

  // High nibble selects the mode, add/and group
  localparam logic [3:0] NIB_INLINE = 4'ha;
  localparam logic [3:0] NIB_ZPAGE  = 4'hb;
  localparam logic [3:0] NIB_FULL   = 4'hc;
  localparam logic [3:0] NIB_PWORD  = 4'hd;
  localparam logic [3:0] NIB_PBYTE  = 4'he;
  localparam logic [3:0] NIB_PNONE  = 4'hf;
  localparam logic [3:0] NIB_SWORD  = 4'hd;
  localparam logic [3:0] NIB_SBYTE  = 4'he;

  // High nibble selects the mode, shift group; high nibble of bit clear
  localparam logic [3:0] NIB_SH_ZPAGE = 4'h3;
  localparam logic [3:0] NIB_SH_ACC   = 4'h4;
  localparam logic [3:0] NIB_SH_XLO   = 4'h5;
  localparam logic [3:0] NIB_SH_PBYTE = 4'h6;
  localparam logic [3:0] NIB_SH_PNONE = 4'h7;
  localparam logic [3:0] NIB_SH_SBYTE = 4'h6;
  localparam logic [3:0] NIB_CLEAR_DIRECT_BIT     = 4'h1;

  // Cycle counts per instruction form
  localparam logic [2:0] CYC_INLINE   = 3'h2;
  localparam logic [2:0] CYC_ZPAGE    = 3'h3;
  localparam logic [2:0] CYC_FULL     = 3'h4;
  localparam logic [2:0] CYC_PWORD    = 3'h4;
  localparam logic [2:0] CYC_PBYTE    = 3'h3;
  localparam logic [2:0] CYC_PNONE    = 3'h2;
  localparam logic [2:0] CYC_SWORD    = 3'h5;
  localparam logic [2:0] CYC_SBYTE    = 3'h4;
  localparam logic [2:0] CYC_SH_ZPAGE = 3'h4;
  localparam logic [2:0] CYC_SH_REG   = 3'h1;
  localparam logic [2:0] CYC_SH_PBYTE = 3'h4;
  localparam logic [2:0] CYC_SH_PNONE = 3'h3;
  localparam logic [2:0] CYC_SH_SBYTE = 3'h5;
  localparam logic [2:0] CYC_ADJ      = 3'h2;
  localparam logic [2:0] CYC_BRANCH   = 3'h3;
  localparam logic [2:0] CYC_CLEAR_DIRECT_BIT     = 3'h4;

  // Flag byte layout
  localparam int FLG_SERR   = 7;
  localparam int FLG_NIB    = 4;
  localparam int FLG_IMASK  = 3;
  localparam int FLG_MSB    = 2;
  localparam int FLG_ZERO   = 1;
  localparam int FLG_BORROW = 0;
  localparam logic [7:0] FLG_FIXED_ONES = 8'h60;

  // Reset values
  localparam logic [7:0]  RST_ACC   = 8'h00;
  localparam logic [15:0] RST_INDEX = 16'h0000;
  localparam logic [15:0] RST_STACK = 16'h00ff;
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [7:0]  RST_FLAGS = 8'h68;

  // Branch base distance
  localparam logic [15:0] BR_BASE = 16'h0002;

  typedef enum logic [2:0] {
    ALX_K_ADD, ALX_K_AND, ALX_K_ASL, ALX_K_ASR,
    ALX_K_STACK_ADJ, ALX_K_INDEX_ADJ, ALX_K_BRANCH, ALX_K_CLEAR_DIRECT_BIT
  } alx_kind_t;

  typedef enum logic [3:0] {
    ALX_M_IMPLIED, ALX_M_INLINE, ALX_M_RELATIVE, ALX_M_ZPAGE,
    ALX_M_FULL_ADDR, ALX_M_PTR_NONE, ALX_M_PTR_BYTE, ALX_M_PTR_WORD,
    ALX_M_STK_BYTE, ALX_M_STK_WORD
  } alx_mode_t;

  typedef enum logic [1:0] {ALX_T_ACC, ALX_T_XLO, ALX_T_MEM} alx_tgt_t;

  // Operand bytes following the opcode
  function automatic logic [1:0] alx_opnd_bytes(input alx_mode_t m);
    case (m)
      ALX_M_IMPLIED, ALX_M_PTR_NONE:                  return 2'd0;
      ALX_M_FULL_ADDR, ALX_M_PTR_WORD, ALX_M_STK_WORD: return 2'd2;
      default:                                        return 2'd1;
    endcase
  endfunction : alx_opnd_bytes

  // Sign extension of an eight-bit offset
  function automatic logic [15:0] alx_sext(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction : alx_sext

endpackage : alx_pkg

//--- hw/alx_decode.sv
// Opcode decoder: operation, mode, target and cycle count
`timescale 1ns/100ps
module alx_decode import alx_pkg::*; (
  // Opcode, prefix in the upper byte
  input  wire logic [15:0] i_opcode,
  // Decoded fields
  output logic             o_valid,
  output alx_kind_t        o_kind,
  output alx_mode_t        o_mode,
  output alx_tgt_t         o_target,
  output logic [2:0]       o_bitsel,
  output logic [2:0]       o_cycles
);

  // Opcode fields
  logic       pre;
  logic [3:0] hi;
  logic [3:0] lo;
  logic       alu_lo;
  logic       sh_lo;
  assign pre    = (i_opcode[15:8] == ALX_PREFIX);
  assign hi     = i_opcode[7:4];
  assign lo     = i_opcode[3:0];
  assign alu_lo = (lo == NIB_ADD) || (lo == NIB_AND);
  assign sh_lo  = (lo == NIB_SHL) || (lo == NIB_SHR);

  // Decode tree
  always_comb begin
    o_valid  = 1'b1;
    o_kind   = (lo == NIB_ADD) ? ALX_K_ADD : ALX_K_AND;
    o_mode   = ALX_M_IMPLIED;
    o_target = ALX_T_ACC;
    o_bitsel = lo[3:1];
    o_cycles = CYC_INLINE;
    if (pre) begin
      if (alu_lo && hi == NIB_SWORD) begin
        o_mode   = ALX_M_STK_WORD;
        o_cycles = CYC_SWORD;
      end else if (alu_lo && hi == NIB_SBYTE) begin
        o_mode   = ALX_M_STK_BYTE;
        o_cycles = CYC_SBYTE;
      end else if (sh_lo && hi == NIB_SH_SBYTE) begin
        o_kind   = (lo == NIB_SHL) ? ALX_K_ASL : ALX_K_ASR;
        o_mode   = ALX_M_STK_BYTE;
        o_target = ALX_T_MEM;
        o_cycles = CYC_SH_SBYTE;
      end else begin
        o_valid = 1'b0;
      end
    end else if (i_opcode[15:8] != ALX_NO_PREFIX) begin
      o_valid = 1'b0;
    end else if (i_opcode[7:0] == OPC_STACK_ADJ) begin
      o_kind   = ALX_K_STACK_ADJ;
      o_mode   = ALX_M_INLINE;
      o_cycles = CYC_ADJ;
    end else if (i_opcode[7:0] == OPC_INDEX_ADJ) begin
      o_kind   = ALX_K_INDEX_ADJ;
      o_mode   = ALX_M_INLINE;
      o_cycles = CYC_ADJ;
    end else if (alu_lo && hi >= NIB_INLINE) begin
      case (hi)
        NIB_INLINE: begin o_mode = ALX_M_INLINE;    o_cycles = CYC_INLINE; end
        NIB_ZPAGE:  begin o_mode = ALX_M_ZPAGE;     o_cycles = CYC_ZPAGE;  end
        NIB_FULL:   begin o_mode = ALX_M_FULL_ADDR; o_cycles = CYC_FULL;   end
        NIB_PWORD:  begin o_mode = ALX_M_PTR_WORD;  o_cycles = CYC_PWORD;  end
        NIB_PBYTE:  begin o_mode = ALX_M_PTR_BYTE;  o_cycles = CYC_PBYTE;  end
        default:    begin o_mode = ALX_M_PTR_NONE;  o_cycles = CYC_PNONE;  end
      endcase
    end else if (sh_lo && hi >= NIB_SH_ZPAGE && hi <= NIB_SH_PNONE) begin
      o_kind   = (lo == NIB_SHL) ? ALX_K_ASL : ALX_K_ASR;
      o_target = ALX_T_MEM;
      case (hi)
        NIB_SH_ZPAGE: begin o_mode = ALX_M_ZPAGE; o_cycles = CYC_SH_ZPAGE; end
        NIB_SH_ACC: begin o_target = ALX_T_ACC; o_cycles = CYC_SH_REG; end
        NIB_SH_XLO: begin o_target = ALX_T_XLO; o_cycles = CYC_SH_REG; end
        NIB_SH_PBYTE: begin
          o_mode = ALX_M_PTR_BYTE; o_cycles = CYC_SH_PBYTE;
        end
        default: begin o_mode = ALX_M_PTR_NONE; o_cycles = CYC_SH_PNONE; end
      endcase
    end else if (i_opcode[7:0] == OPC_BR_CC) begin
      o_kind   = ALX_K_BRANCH;
      o_mode   = ALX_M_RELATIVE;
      o_cycles = CYC_BRANCH;
    end else if (hi == NIB_CLEAR_DIRECT_BIT && lo[0]) begin
      o_kind   = ALX_K_CLEAR_DIRECT_BIT;
      o_mode   = ALX_M_ZPAGE;
      o_target = ALX_T_MEM;
      o_cycles = CYC_CLEAR_DIRECT_BIT;
    end else begin
      o_valid = 1'b0;
    end
  end

endmodule : alx_decode

//--- hw/alx_alu.sv
// Eight-bit result and flag byte computation
`timescale 1ns/100ps
module alx_alu import alx_pkg::*; (
  // Operation and operands
  input  alx_kind_t        i_kind,
  input  wire logic [7:0]  i_target,
  input  wire logic [7:0]  i_operand,
  input  wire logic [2:0]  i_bitsel,
  input  wire logic [7:0]  i_flags,
  // Result
  output logic [7:0]       o_result,
  output logic [7:0]       o_flags
);

  // Full and low-nibble sums
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic       nz_kind;
  logic       sh_kind;
  assign sum9    = {1'b0, i_target} + {1'b0, i_operand};
  assign nib5    = {1'b0, i_target[3:0]} + {1'b0, i_operand[3:0]};
  assign sh_kind = (i_kind == ALX_K_ASL) || (i_kind == ALX_K_ASR);
  assign nz_kind = sh_kind || (i_kind == ALX_K_ADD) || (i_kind == ALX_K_AND);

  // Result and flags; untouched flags keep their value
  always_comb begin
    o_result = i_target;
    o_flags  = i_flags;
    case (i_kind)
      ALX_K_ADD: begin
        o_result = sum9[7:0];
        o_flags[FLG_SERR] = (i_target[7] == i_operand[7]) &&
                            (sum9[7] != i_target[7]);
        o_flags[FLG_NIB]    = nib5[4];
        o_flags[FLG_BORROW] = sum9[8];
      end
      ALX_K_AND: begin
        o_result = i_target & i_operand;
        o_flags[FLG_SERR] = 1'b0;
      end
      ALX_K_ASL: begin
        o_result = {i_target[6:0], 1'b0};
        o_flags[FLG_BORROW] = i_target[7];
      end
      ALX_K_ASR: begin
        o_result = {i_target[7], i_target[7:1]};
        o_flags[FLG_BORROW] = i_target[0];
      end
      ALX_K_CLEAR_DIRECT_BIT: o_result = i_target & ~(8'h01 << i_bitsel);
      default: ;
    endcase
    if (nz_kind) begin
      o_flags[FLG_MSB]  = o_result[7];
      o_flags[FLG_ZERO] = (o_result == 8'h00);
    end
    if (sh_kind) begin
      o_flags[FLG_SERR] = o_flags[FLG_MSB] ^ o_flags[FLG_BORROW];
    end
  end

endmodule : alx_alu

//--- testbench/alx_mem_model.sv
// Program and data memory model with asynchronous read
`timescale 1ns/100ps
module alx_mem_model (
  // Clock
  input  wire logic        i_clock,
  // Bus from the datapath
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h00;
  // Idle bus shows the inverse of the last byte
  assign o_rdata = i_rd ? mem[i_addr] : ~last_reg;
  // Write port and last value
  always @(posedge i_clock) begin
    if (i_wr)
      mem[i_addr] <= i_wdata;
    if (i_rd)
      last_reg <= mem[i_addr];
  end
endmodule : alx_mem_model

//--- testbench/alx_exec_tb.sv
// Self-checking bench for the execution datapath
`timescale 1ns/100ps
module alx_exec_tb import alx_pkg::*;;
  logic        i_clock, i_reset, i_start, i_load, o_busy, o_done;
  logic        o_bad_opcode, o_mem_rd, o_mem_wr;
  logic [15:0] i_opcode, i_load_index, i_load_stack, i_load_pc;
  logic [15:0] o_mem_addr, o_index, o_stack_top, o_pc;
  logic [7:0]  i_load_acc, i_load_flags, i_mem_rdata, o_mem_wdata;
  logic [7:0]  o_acc, o_flags;
  logic [65:0] exp_q[$];
  int          mismatches, n_tests;
  logic [7:0]  ops[12] = '{8'hab, 8'ha4, 8'h48, 8'h47, 8'ha7, 8'haf, 8'h24,
                           8'hfb, 8'h77, 8'h78, 8'h11, 8'h10};

  alx_exec alx_exec_inst (.i_clock(i_clock), .i_reset(i_reset),
    .i_start(i_start), .i_opcode(i_opcode), .o_busy(o_busy),
    .o_done(o_done), .o_bad_opcode(o_bad_opcode), .o_mem_addr(o_mem_addr),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata),
    .i_mem_rdata(i_mem_rdata), .i_load(i_load), .i_load_acc(i_load_acc),
    .i_load_index(i_load_index), .i_load_stack(i_load_stack),
    .i_load_pc(i_load_pc), .i_load_flags(i_load_flags), .o_acc(o_acc),
    .o_index(o_index), .o_stack_top(o_stack_top), .o_pc(o_pc),
    .o_flags(o_flags));
  alx_mem_model alx_mem_model_inst (.i_clock(i_clock), .i_addr(o_mem_addr),
    .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_wdata(o_mem_wdata),
    .o_rdata(i_mem_rdata));

  // Expected memory result, acc, flags, index, stack, pc
  function automatic logic [71:0] model(input logic [7:0] op, a, m, f,
      input logic [15:0] x, s, p);
    logic [7:0]  r, t;
    logic [15:0] e;
    logic        sh, nz;
    sh = (op[7:4] == 4'h4) || (op[7:4] == 4'h7);
    nz = (op[3:0] == 4'hb) || (op == 8'ha4);
    t = (op[7:4] == 4'h4) ? a : m;
    r = t;
    e = {{8{m[7]}}, m};
    f = f | 8'h60;
    case (op)
      8'hab, 8'hfb: begin
        r = a + m;
        f[7] = (a[7] & m[7] & ~r[7]) | (~a[7] & ~m[7] & r[7]);
        f[4] = (a[3] & m[3]) | (m[3] & ~r[3]) | (~r[3] & a[3]);
        f[0] = (a[7] & m[7]) | (m[7] & ~r[7]) | (~r[7] & a[7]);
      end
      8'ha4: begin
        r = a & m;
        f[7] = 1'b0;
      end
      8'h48, 8'h78: begin
        r = {t[6:0], 1'b0};
        f[0] = t[7];
      end
      8'h47, 8'h77: begin
        r = {t[7], t[7:1]};
        f[0] = t[0];
      end
      8'h11: r = m & 8'hfe;
      8'ha7: s = s + e;
      8'haf: x = x + e;
      8'h24: p = f[0] ? p : p + e;
      default: ;
    endcase
    if (sh || nz) begin
      f[2] = r[7];
      f[1] = (r == 8'h00);
    end
    if (sh)
      f[7] = f[2] ^ f[0];
    if (op != 8'h10)
      p = p + ((sh || op == 8'hfb) ? 16'h0001 : 16'h0002);
    return {r, (nz || op[7:4] == 4'h4) ? r : a, f, x, s, p};
  endfunction : model

  task automatic check(input logic [65:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Load random state, then start one instruction
  task automatic run(input logic [7:0] op);
    logic [63:0] v;
    logic [71:0] w;
    logic [15:0] ma;
    logic [7:0]  m;
    v = {$urandom, $urandom};
    m = 8'($urandom);
    // Operand byte, pointed byte and zero-page byte all hold m
    alx_mem_model_inst.mem[v[63:48] + 16'h0001] = m;
    alx_mem_model_inst.mem[v[31:16]] = m;
    alx_mem_model_inst.mem[{8'h00, m}] = m;
    w = model(op, v[7:0], m, v[15:8], v[31:16], v[47:32], v[63:48]);
    ma = (op == 8'h11) ? {8'h00, m} : v[31:16];
    {i_load_pc, i_load_stack, i_load_index, i_load_flags, i_load_acc} = v;
    i_load = 1'b1;
    @(posedge i_clock) #1;
    i_load = 1'b0;
    i_start = 1'b1;
    i_opcode = {8'h00, op};
    exp_q.push_back({op == 8'h10, 1'b0, w[63:0]});
    @(posedge i_clock) #1;
    i_start = 1'b0;
    for (int k = 0; k < 8 && o_done !== 1'b1; k++)
      @(negedge i_clock);
    @(posedge i_clock) #1;
    // Written-back byte of memory forms
    if (op[7:4] == 4'h7 || op == 8'h11)
      check(66'(alx_mem_model_inst.mem[ma]), 66'(w[71:64]));
    $display("op %h finished", op);
  endtask : run

  // Clock
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  // Result watcher
  always @(negedge i_clock) begin
    if (o_done === 1'b1 && exp_q.size() > 0)
      check({o_bad_opcode, o_busy, o_acc, o_flags, o_index, o_stack_top,
             o_pc}, exp_q.pop_front());
  end

  // Main sequence
  initial begin
    {i_start, i_load, i_opcode, i_load_acc, i_load_flags} = '0;
    {i_load_index, i_load_stack, i_load_pc} = '0;
    i_reset = 1'b1;
    void'($urandom(32'hdc2037f3));
    repeat (16) @(posedge i_clock);
    #1 i_reset = 1'b0;
    check({o_bad_opcode, o_busy, o_acc, o_flags, o_index, o_stack_top,
           o_pc}, {2'b00, RST_ACC, RST_FLAGS, RST_INDEX, RST_STACK,
           RST_PC});
    for (int i = 0; i < 72; i++)
      run(ops[i % 12]);
    // Every started instruction must have finished
    check(66'(exp_q.size()), 66'h0);
    conclude();
  end

  // Watchdog
  initial begin
    #6000;
    mismatches++;
    conclude();
  end
endmodule : alx_exec_tb
